// *** src/sssx_pkg.sv ***
/*
  Package for the shift/subtract/store/sleep execution block: opcodes,
  function codes, exception codes, power states and reset values.
  Assumes a single 20 MHz core clock and a synchronous active-high reset.
*/
`default_nettype none
package sssx_pkg;
  // major opcodes and function codes
  localparam logic [5:0] PRIMARY_GROUP_ZERO = 6'h00;
  localparam logic [5:0] SYSTEM_COPROCESSOR_GROUP = 6'h10;
  localparam logic [5:0] STORE_WORD_OP = 6'h2b;
  localparam logic [5:0] STORE_LEFT_PART_OP = 6'h2a;
  localparam logic [5:0] LOGICAL_RIGHT_SHIFT_IMM_OP = 6'h02;
  localparam logic [5:0] LOGICAL_RIGHT_SHIFT_VAR_OP = 6'h06;
  localparam logic [5:0] ARITH_RIGHT_SHIFT_VAR_OP = 6'h07;
  localparam logic [5:0] MINUS_TRAPPING_OP = 6'h22;
  localparam logic [5:0] MINUS_NONTRAPPING_OP = 6'h23;
  localparam logic [5:0] LIGHT_SLEEP_OP = 6'h21;
  localparam logic [5:0] DEEP_SLEEP_OP = 6'h22;
  // instruction field positions
  localparam int OPC_LSB = 26;
  localparam int FIRST_LSB = 21;
  localparam int SECOND_LSB = 16;
  localparam int DEST_LSB = 11;
  localparam int SHAMT_LSB = 6;
  localparam int SYSFN_BIT = 25;
  localparam int ZERO19_LSB = 6;
  // exception codes reported with excValid
  localparam logic [2:0] EXC_NONE = 3'h0;
  localparam logic [2:0] EXC_OVERFLOW = 3'h1;
  localparam logic [2:0] EXC_ADDR_ERROR = 3'h2;
  localparam logic [2:0] EXC_COP_UNUSABLE = 3'h3;
  localparam logic [2:0] EXC_TLB_REFILL = 3'h4;
  localparam logic [2:0] EXC_TLB_INVALID = 3'h5;
  localparam logic [2:0] EXC_TLB_MODIFY = 3'h6;
  localparam logic [2:0] EXC_BUS_ERROR = 3'h7;
  // reset values
  localparam logic [63:0] RESET_DATA = 64'h0;
  localparam logic [4:0] RESET_REG = 5'h0;
  localparam logic [1:0] RESET_SETTLE = 2'h0;
  // idle is trusted only after both synchroniser stages have refreshed
  localparam logic [1:0] IDLE_SETTLE = 2'h2;
  // power states
  typedef enum logic [2:0] {
    SSSX_FULL = 3'b000,
    SSSX_LIGHT_WAIT = 3'b001,
    SSSX_LIGHT = 3'b010,
    SSSX_DEEP_WAIT = 3'b011,
    SSSX_DEEP = 3'b100
  } sssx_power_t;
endpackage : sssx_pkg
`default_nettype wire

// *** src/sssx_sync2.sv ***
/*
  Two-flop synchroniser for a bundle of asynchronous level inputs.
  Assumes the inputs are levels held long enough to be seen.
*/
`default_nettype none
module sssx_sync2 #(
  parameter int W = 4
) (
  input wire logic mclk,         // core clock
  input wire logic reset,        // sync reset, active high
  input wire logic [W-1:0] din,  // asynchronous levels
  output logic [W-1:0] dout      // synchronised levels
);
  logic [W-1:0] stage1;

  // first stage is read by the second stage only
  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : sssx_sync2
`default_nettype wire

// *** src/sssx_exec.sv ***
/*
  Execution unit for right shifts, subtracts, word and left-part stores
  and the two sleep instructions. At full speed one instruction is accepted per issue
  pulse; results and store requests come out of flops the next cycle.
  Assumes the decoder supplies operand values, and that the memory side
  reports translation/bus faults with a one-cycle pulse per store.
*/
// The implementer's own choices: the address-and-strobe port and the register addresses.
`default_nettype none
module sssx_exec (
  input wire logic mclk,                  // core clock, 20 MHz
  input wire logic reset,                 // sync reset, active high
  input wire logic issueValid,            // one-cycle pulse: instruction present
  input wire logic [31:0] instrWord,      // instruction word
  input wire logic [63:0] firstOperand,   // value of first_operand_reg (also store base)
  input wire logic [63:0] secondOperand,  // value of second_operand_reg
  input wire logic mode64,                // 64-bit mode level
  input wire logic copUsable,             // system coprocessor access permitted
  input wire logic busIdle,               // system_address_data_bus idle, async level
  input wire logic intPending,            // any interrupt incl. timer, async level
  input wire logic nmiReq,                // non-maskable interrupt, async level
  input wire logic softResetReq,          // soft reset request, async level
  input wire logic memTlbRefill,          // store fault pulses from translation
  input wire logic memTlbInvalid,         // translation invalid pulse
  input wire logic memTlbModify,          // translation modification pulse
  input wire logic memBusError,           // bus error pulse
  output logic resultValid,               // pulse: destination write
  output logic [4:0] resultReg,           // destination register number
  output logic [63:0] resultData,         // destination value
  output logic excValid,                  // pulse: exception taken
  output logic [2:0] excCode,             // exception kind
  output logic storeValid,                // pulse: store request
  output logic [63:0] storeAddr,          // virtual store address
  output logic [1:0] storeType,           // access type (bytes-1)
  output logic [2:0] storeOffset,         // doubleword byte offset
  output logic [63:0] storeData,          // doubleword store data
  output logic [7:0] storeByteEn,         // byte lanes written
  output logic coreClockEn,               // enable for internal core clocks
  output logic busClockEn,                // enable for bus_side_clock
  output logic refClockEn,                // enable for reference_clock_output
  output logic timerClockEn,              // enable for PLL/timer/interrupt clocks
  output logic pipeFrozen                 // pipeline frozen in a sleep mode
);
  import sssx_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // sign-extend a 32-bit word result
  function automatic logic [63:0] sext32(input logic [31:0] w);
    sext32 = {{32{w[31]}}, w};
  endfunction : sext32

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire logic [5:0] opc = instrWord[31:OPC_LSB];
  wire logic [5:0] fn = instrWord[5:0];
  wire logic [4:0] destReg = instrWord[15:DEST_LSB];
  wire logic [4:0] shiftAmount = instrWord[10:SHAMT_LSB];
  wire logic [4:0] varAmount = firstOperand[4:0];
  wire logic isGroupZero = (opc == PRIMARY_GROUP_ZERO);
  wire logic isSra = isGroupZero && (fn == ARITH_RIGHT_SHIFT_VAR_OP);
  wire logic isSrl = isGroupZero && (fn == LOGICAL_RIGHT_SHIFT_IMM_OP);
  wire logic isSrlv = isGroupZero && (fn == LOGICAL_RIGHT_SHIFT_VAR_OP);
  wire logic isSub = isGroupZero && (fn == MINUS_TRAPPING_OP);
  wire logic isSubu = isGroupZero && (fn == MINUS_NONTRAPPING_OP);
  // sleep forms need the function bit and an all-zero 19-bit field
  wire logic isSysFmt = (opc == SYSTEM_COPROCESSOR_GROUP) && instrWord[SYSFN_BIT]
                        && (instrWord[24:ZERO19_LSB] == 19'h0);
  wire logic isLight = isSysFmt && (fn == LIGHT_SLEEP_OP);
  wire logic isDeep = isSysFmt && (fn == DEEP_SLEEP_OP);
  wire logic isSw = (opc == STORE_WORD_OP);
  wire logic isSwl = (opc == STORE_LEFT_PART_OP);

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // operands are taken as sign-extended words; upper halves are ignored
  wire logic [31:0] opA = firstOperand[31:0];
  wire logic [31:0] opB = secondOperand[31:0];
  wire logic [31:0] sraRes = $signed(opB) >>> varAmount;
  wire logic [31:0] srlRes = opB >> shiftAmount;
  wire logic [31:0] srlvRes = opB >> varAmount;
  wire logic [32:0] diffFull = {1'b0, opA} + {1'b0, ~opB} + 33'h1;
  wire logic [31:0] diff = diffFull[31:0];
  // carry into bit 31 vs carry out of bit 31
  wire logic carry30 = opA[31] ^ ~opB[31] ^ diff[31];
  wire logic subOverflow = carry30 ^ diffFull[32];
  logic [31:0] aluWord;
  assign aluWord = isSra ? sraRes : isSrl ? srlRes : isSrlv ? srlvRes : diff;
  wire logic aluOp = isSra || isSrl || isSrlv || isSub || isSubu;
  // 32-bit mode keeps the plain word; upper half zero
  wire logic [63:0] aluOut = mode64 ? sext32(aluWord) : {32'h0, aluWord};

  // ----------------------------------------------------------------
  // store address and lanes
  // ----------------------------------------------------------------
  wire logic [63:0] effAddr = firstOperand + {{48{instrWord[15]}}, instrWord[15:0]};
  wire logic swMisaligned = (effAddr[1:0] != 2'b00);
  wire logic [1:0] swlByte = effAddr[1:0];
  wire logic [4:0] swlShift = 5'(8 * (3 - swlByte));
  // top (byte+1) register bytes placed so the MSB lands on the addressed byte
  wire logic [31:0] swlWord = opB >> swlShift;
  wire logic [3:0] swlLanes = 4'(4'hf >> (3 - swlByte));
  wire logic hiWord = effAddr[2];
  wire logic [63:0] swlData = hiWord ? {swlWord, 32'h0} : {32'h0, swlWord};
  wire logic [7:0] swlEn = hiWord ? {swlLanes, 4'h0} : {4'h0, swlLanes};
  wire logic [63:0] swData = hiWord ? {opB, 32'h0} : {32'h0, opB};
  wire logic [7:0] swEn = hiWord ? 8'hf0 : 8'h0f;

  // ----------------------------------------------------------------
  // synchronised wake and idle levels
  // ----------------------------------------------------------------
  logic [3:0] asyncSync;
  sssx_sync2 #(.W(4)) uSync (
    .mclk(mclk),
    .reset(reset),
    .din({busIdle, intPending, nmiReq, softResetReq}),
    .dout(asyncSync)
  );
  wire logic busIdleS = asyncSync[3];
  // any interrupt, nmi or soft reset wakes; cold reset is the reset port
  wire logic wakeReq = |asyncSync[2:0];

  // ----------------------------------------------------------------
  // issue: results, exceptions and stores
  // ----------------------------------------------------------------
  sssx_power_t pwr, next_pwr;
  logic [1:0] settleCnt;
  // new work is taken at full speed only; a draining sleep refuses it
  wire logic running = (pwr == SSSX_FULL);
  wire logic drainDone = busIdleS && (settleCnt == 2'h0);
  wire logic go = issueValid && running;
  wire logic sleepDenied = (isLight || isDeep) && !copUsable;
  wire logic overflowTrap = isSub && subOverflow;
  wire logic swFault = isSw && swMisaligned;
  // the register is written only when no overflow trap is taken
  wire logic next_resultValid = go && aluOp && !overflowTrap;
  wire logic next_store = go && ((isSw && !swMisaligned) || isSwl);
  logic storePending;
  // a memory fault arrives while a store is outstanding
  wire logic memFault = storePending && (memTlbRefill || memTlbInvalid || memTlbModify || memBusError);
  logic [2:0] memCode;
  assign memCode = memTlbRefill ? EXC_TLB_REFILL : memTlbInvalid ? EXC_TLB_INVALID :
                   memTlbModify ? EXC_TLB_MODIFY : EXC_BUS_ERROR;

  // register writeback
  always_ff @(posedge mclk) begin
    if (reset) begin
      resultValid <= 1'b0;
      resultReg <= RESET_REG;
      resultData <= RESET_DATA;
    end else begin
      resultValid <= next_resultValid;
      if (next_resultValid) begin
        resultReg <= destReg;
        resultData <= aluOut;
      end
    end
  end

  // exception report; decode-time faults win over a late memory fault
  always_ff @(posedge mclk) begin
    if (reset) begin
      excValid <= 1'b0;
      excCode <= EXC_NONE;
    end else if (go && (overflowTrap || swFault || sleepDenied)) begin
      excValid <= 1'b1;
      excCode <= overflowTrap ? EXC_OVERFLOW : swFault ? EXC_ADDR_ERROR : EXC_COP_UNUSABLE;
    end else if (memFault) begin
      excValid <= 1'b1;
      excCode <= memCode;
    end else begin
      excValid <= 1'b0;
      excCode <= EXC_NONE;
    end
  end

  // store request; type and offset follow little-endian memory
  always_ff @(posedge mclk) begin
    if (reset) begin
      storeValid <= 1'b0;
      storeAddr <= RESET_DATA;
      storeType <= 2'h0;
      storeOffset <= 3'h0;
      storeData <= RESET_DATA;
      storeByteEn <= 8'h0;
    end else begin
      storeValid <= next_store;
      if (next_store) begin
        storeAddr <= effAddr;
        storeType <= isSwl ? swlByte : 2'h3;
        storeOffset <= {hiWord, 2'b00};
        storeData <= isSwl ? swlData : swData;
        storeByteEn <= isSwl ? swlEn : swEn;
      end
    end
  end

  // one store outstanding until its next cycle; fault pulses come then
  always_ff @(posedge mclk) begin
    if (reset) begin
      storePending <= 1'b0;
    end else begin
      storePending <= next_store;
    end
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  // the synchronised idle level lags the bus by two stages, so a store
  // issued just before the sleep could still look idle; wait it out
  always_ff @(posedge mclk) begin
    if (reset) begin
      settleCnt <= RESET_SETTLE;
    end else if (pwr == SSSX_FULL) begin
      settleCnt <= IDLE_SETTLE;
    end else if (settleCnt != 2'h0) begin
      settleCnt <= settleCnt - 2'h1;
    end
  end

  // writeback of the sleep instruction is the issue cycle here, so the
  // wait for bus idle starts on the following edge
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      SSSX_FULL: begin
        if (go && isLight && copUsable) begin
          next_pwr = SSSX_LIGHT_WAIT;
        end else if (go && isDeep && copUsable) begin
          next_pwr = SSSX_DEEP_WAIT;
        end
      end
      SSSX_LIGHT_WAIT: begin
        if (wakeReq) begin
          next_pwr = SSSX_FULL;
        end else if (drainDone) begin
          next_pwr = SSSX_LIGHT;
        end
      end
      SSSX_DEEP_WAIT: begin
        if (wakeReq) begin
          next_pwr = SSSX_FULL;
        end else if (drainDone) begin
          next_pwr = SSSX_DEEP;
        end
      end
      SSSX_LIGHT: begin
        if (wakeReq) begin
          next_pwr = SSSX_FULL;
        end
      end
      SSSX_DEEP: begin
        if (wakeReq) begin
          next_pwr = SSSX_FULL;
        end
      end
      default: next_pwr = SSSX_FULL;
    endcase
  end

  // cold reset always returns to full speed
  always_ff @(posedge mclk) begin
    if (reset) begin
      pwr <= SSSX_FULL;
    end else begin
      pwr <= next_pwr;
    end
  end

  // clock enables; the wait states still run the core so the bus can drain
  wire logic sleeping = (pwr == SSSX_LIGHT) || (pwr == SSSX_DEEP);
  assign coreClockEn = !sleeping;
  assign busClockEn = (pwr != SSSX_DEEP);
  assign refClockEn = 1'b1;
  assign timerClockEn = 1'b1;
  assign pipeFrozen = !coreClockEn;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_sub_overflow_trap: assert property (go && isSub && (opA[31] != opB[31]) && (diff[31] != opA[31])
    |=> excValid && excCode == EXC_OVERFLOW && !resultValid)
    else $error("overflowing subtract did not trap cleanly");
  a_minus_nontrapping_op_no_trap: assert property (go && isSubu |=> resultValid && !(excValid && excCode == EXC_OVERFLOW))
    else $error("nontrapping subtract misbehaved");
  a_sra_result: assert property (go && isSra && mode64 |=> resultData == sext32(32'($signed($past(opB)) >>> $past(varAmount))))
    else $error("arithmetic shift result wrong");
  a_srl_zero_fill: assert property (go && isSrl && shiftAmount != 5'h0 && !mode64 |=> resultData[31] == 1'b0)
    else $error("logical shift did not zero fill");
  a_logical_right_shift_var_op_low_bits: assert property (go && isSrlv |=> resultData[31:0] == ($past(opB) >> $past(firstOperand[4:0])))
    else $error("variable logical shift count wrong");
  a_sw_misaligned: assert property (go && isSw && effAddr[1:0] != 2'b00 |=> excValid && excCode == EXC_ADDR_ERROR && !storeValid)
    else $error("misaligned word store not faulted");
  a_swl_no_align: assert property (go && isSwl |=> storeValid && storeType == $past(effAddr[1:0]) && !excValid)
    else $error("left store faulted or wrong type");
  a_sleep_denied: assert property (go && (isLight || isDeep) && !copUsable
    |=> excValid && excCode == EXC_COP_UNUSABLE && coreClockEn && (pwr == SSSX_FULL))
    else $error("sleep without permission not refused");

  sequence s_light_drained;
    (pwr == SSSX_LIGHT_WAIT) && (settleCnt == 2'h0) && busIdleS && !wakeReq;
  endsequence
  sequence s_deep_drained;
    (pwr == SSSX_DEEP_WAIT) && (settleCnt == 2'h0) && busIdleS && !wakeReq;
  endsequence
  a_drain_runs: assert property (go && (isLight || isDeep) && copUsable |=> coreClockEn [*3])
    else $error("core clock stopped before the bus drained");
  a_light_stop: assert property (s_light_drained |=> !coreClockEn && busClockEn && refClockEn && timerClockEn)
    else $error("light sleep clocks wrong");
  a_deep_bus_clock: assert property (s_deep_drained |=> !coreClockEn && !busClockEn && refClockEn && timerClockEn)
    else $error("deep sleep kept bus clock running");
  a_light_wake: assert property ((pwr == SSSX_LIGHT) && wakeReq |=> coreClockEn && busClockEn)
    else $error("light sleep did not wake");
  a_deep_wake: assert property ((pwr == SSSX_DEEP) && wakeReq |=> coreClockEn)
    else $error("deep sleep did not wake");
  a_store_fault: assert property (storePending && memTlbModify && !(go && (overflowTrap || swFault || sleepDenied))
    |=> excValid && excCode == EXC_TLB_MODIFY)
    else $error("store fault not reported");
endmodule : sssx_exec
`default_nettype wire

// *** sim/sssx_mem_model.sv ***
/*
  Memory-side model of the store path: fault pulses and bus activity.
  Assumes one clock shared with the execution unit and a sync reset.
*/
`default_nettype none
module sssx_mem_model (
  input wire logic mclk,           // core clock
  input wire logic reset,          // sync reset, active high
  input wire logic storeValid,     // store request pulse
  input wire logic [2:0] faultSel, // 0 none, 1 refill .. 4 bus error
  input wire logic [3:0] busyLen,  // bus busy cycles after a store
  output logic busIdle,            // bus idle level
  output logic memTlbRefill,       // refill pulse
  output logic memTlbInvalid,      // invalid pulse
  output logic memTlbModify,       // modify pulse
  output logic memBusError         // bus error pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] busyCnt;
  // faults answer in the store cycle itself, where the unit samples them
  assign memTlbRefill = storeValid && (faultSel == 3'h1);
  assign memTlbInvalid = storeValid && (faultSel == 3'h2);
  assign memTlbModify = storeValid && (faultSel == 3'h3);
  assign memBusError = storeValid && (faultSel == 3'h4);
  // bus stays busy after each store, so a sleep entry has to wait
  always_ff @(posedge mclk) begin
    if (reset) begin
      busyCnt <= 4'h0;
    end else if (storeValid) begin
      busyCnt <= busyLen;
    end else if (busyCnt != 4'h0) begin
      busyCnt <= busyCnt - 4'h1;
    end
  end
  assign busIdle = (busyCnt == 4'h0);
endmodule : sssx_mem_model
`default_nettype wire

// *** sim/tb_top.sv ***
/*
  Self-checking bench for the execution unit with a memory-side model.
  Assumes the unit's one-cycle answer and 2-flop wake synchronisers.
*/
`default_nettype none
module tb_top;
  import sssx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, issueValid = 0, mode64 = 0, copUsable = 1;
  logic intPending = 0, nmiReq = 0, softResetReq = 0;
  logic [31:0] instrWord = 0;
  logic [63:0] firstOperand = 0, secondOperand = 0;
  logic [2:0] faultSel = 0;
  logic [3:0] busyLen = 0;
  wire logic busIdle, memTlbRefill, memTlbInvalid, memTlbModify, memBusError;
  wire logic resultValid, excValid, storeValid, coreClockEn, busClockEn, refClockEn, timerClockEn, pipeFrozen;
  wire logic [4:0] resultReg;
  wire logic [63:0] resultData, storeAddr, storeData;
  wire logic [2:0] excCode, storeOffset;
  wire logic [1:0] storeType;
  wire logic [7:0] storeByteEn;
  int err_total = 0, comparisons = 0;
  // mode and permission levels, applied by the issue task at the clock edge
  bit md = 1'b0, cu = 1'b1;
  always #25 mclk = ~mclk;
  sssx_exec uut (.mclk, .reset, .issueValid, .instrWord, .firstOperand, .secondOperand, .mode64, .copUsable,
    .busIdle, .intPending, .nmiReq, .softResetReq, .memTlbRefill, .memTlbInvalid, .memTlbModify,
    .memBusError, .resultValid, .resultReg, .resultData, .excValid, .excCode, .storeValid, .storeAddr,
    .storeType, .storeOffset, .storeData, .storeByteEn, .coreClockEn, .busClockEn, .refClockEn,
    .timerClockEn, .pipeFrozen);
  sssx_mem_model mem (.mclk, .reset, .storeValid, .faultSel, .busyLen, .busIdle, .memTlbRefill,
    .memTlbInvalid, .memTlbModify, .memBusError);
  // ----------------------------------------
  // checking and issue helpers
  // ----------------------------------------
  task chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task stop_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // one-cycle issue pulse; returns just after the answer edge
  task issue(input logic [31:0] iw, input logic [63:0] a, input logic [63:0] b);
    @(posedge mclk);
    issueValid <= 1'b1;
    instrWord <= iw;
    firstOperand <= a;
    secondOperand <= b;
    mode64 <= md;
    copUsable <= cu;
    @(posedge mclk);
    issueValid <= 1'b0;
    #1;
  endtask : issue
  // bounded wait on wake (sel=1) or freeze (sel=0)
  task wait_sig(input bit sel);
    for (int t = 0; t < 16; t++) begin
      @(posedge mclk);
      #1;
      if ((sel ? coreClockEn : pipeFrozen) === 1'b1) return;
    end
    chk(1'b0, "wait timed out");
    stop_test();
  endtask : wait_sig
  function automatic logic [63:0] ext(input logic [31:0] v);
    return md ? {{32{v[31]}}, v} : {32'h0, v};
  endfunction : ext
  function automatic logic [31:0] shexp(input logic [5:0] fn, input logic [4:0] n, input logic [31:0] v);
    if (fn == ARITH_RIGHT_SHIFT_VAR_OP) return 32'($signed(v) >>> n);
    return v >> n;
  endfunction : shexp
  function automatic logic [63:0] lanes(input logic [7:0] be);
    for (int k = 0; k < 8; k++) lanes[8*k+:8] = {8{be[k]}};
  endfunction : lanes
  logic [5:0] ops [5] = '{ARITH_RIGHT_SHIFT_VAR_OP, LOGICAL_RIGHT_SHIFT_IMM_OP, LOGICAL_RIGHT_SHIFT_VAR_OP,
    MINUS_TRAPPING_OP, MINUS_NONTRAPPING_OP};
  initial begin
    logic [31:0] a, b, d, w;
    logic [5:0] fn;
    logic [4:0] n, rd;
    logic [15:0] imm;
    logic [63:0] base, addr, ex, m;
    logic [2:0] low;
    logic [1:0] bb;
    logic [7:0] be;
    bit si, sw, deep;
    a = $urandom(894);
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    // random shifts and subtracts, overflow corners first
    for (int i = 0; i < 60; i++) begin
      fn = ops[i % 5];
      si = (fn == LOGICAL_RIGHT_SHIFT_IMM_OP);
      a = (i < 5) ? 32'h7fffffff : (i < 10) ? 32'h80000000 : $urandom;
      b = (i < 5) ? 32'hffffffff : (i < 10) ? 32'h00000001 : $urandom;
      n = $urandom;
      rd = $urandom;
      md = 1'($urandom);
      issue({6'h00, si ? 5'h0 : 5'h3, 5'h4, rd, si ? n : 5'h0, fn}, ext(a), ext(b));
      d = a - b;
      if (fn == MINUS_TRAPPING_OP && a[31] != b[31] && d[31] != a[31]) begin
        chk(excValid === 1'b1 && excCode === EXC_OVERFLOW && resultValid === 1'b0, "sub overflow");
        continue;
      end
      if (fn != MINUS_TRAPPING_OP && fn != MINUS_NONTRAPPING_OP) d = shexp(fn, si ? n : a[4:0], b);
      chk(resultValid === 1'b1 && excValid === 1'b0 && resultReg === rd && resultData === ext(d), "alu result");
    end
    // word stores (aligned, misaligned, every fault) then left stores
    for (int i = 0; i < 32; i++) begin
      sw = (i < 16);
      low = sw ? {i[2], (i[1:0] == 2'h3) ? 2'h2 : 2'h0} : i[2:0];
      faultSel = (sw && i[1:0] == 2'h0) ? 3'(i / 4 + 1) : 3'h0;
      imm = $urandom;
      b = $urandom;
      base = {$urandom, $urandom};
      addr = base + {{48{imm[15]}}, imm};
      base = base - addr[2:0] + low;
      addr = {addr[63:3], low};
      issue({sw ? STORE_WORD_OP : STORE_LEFT_PART_OP, 5'h5, 5'h6, imm}, base, {32'h0, b});
      if (sw && low[1:0] != 2'h0) begin
        chk(excValid === 1'b1 && excCode === EXC_ADDR_ERROR && storeValid === 1'b0, "misaligned store");
        continue;
      end
      bb = sw ? 2'h3 : low[1:0];
      be = (8'h0f >> (2'h3 - bb)) << (low[2] ? 4 : 0);
      w = b >> (8 * (2'h3 - bb));
      ex = low[2] ? {w, 32'h0} : {32'h0, w};
      m = lanes(be);
      chk(storeValid === 1'b1 && excValid === 1'b0 && storeAddr === addr && storeType === bb && storeByteEn === be && (storeData & m) === (ex & m), "store fields");
      if (!sw) chk(storeOffset === {low[2], 2'b00}, "left store offset");
      @(posedge mclk);
      #1;
      chk(excValid === (faultSel != 3'h0) && (faultSel == 3'h0 || excCode === faultSel + 3'h3), "store fault");
    end
    faultSel = 3'h0;
    // sleep refused without coprocessor permission
    cu = 1'b0;
    for (int k = 0; k < 2; k++) begin
      issue({SYSTEM_COPROCESSOR_GROUP, 1'b1, 19'h0, k ? DEEP_SLEEP_OP : LIGHT_SLEEP_OP}, 64'h0, 64'h0);
      chk(excValid === 1'b1 && excCode === EXC_COP_UNUSABLE && coreClockEn === 1'b1, "denied sleep");
    end
    cu = 1'b1;
    busyLen = 4'h6;
    // both sleeps behind a busy bus, woken by each source in turn
    for (int k = 0; k < 8; k++) begin
      deep = k[0];
      issue({STORE_WORD_OP, 5'h5, 5'h6, 16'h0}, 64'h100, 64'h0);
      issue({SYSTEM_COPROCESSOR_GROUP, 1'b1, 19'h0, deep ? DEEP_SLEEP_OP : LIGHT_SLEEP_OP}, 64'h0, 64'h0);
      chk(coreClockEn === 1'b1 && pipeFrozen === 1'b0 && busIdle === 1'b0, "sleep drain");
      wait_sig(1'b0);
      chk(busIdle === 1'b1 && coreClockEn === 1'b0 && busClockEn === !deep && refClockEn === 1'b1 && timerClockEn === 1'b1, "sleep clocks");
      @(posedge mclk);
      case (k[2:1])
        2'h0: intPending <= 1'b1;
        2'h1: nmiReq <= 1'b1;
        2'h2: softResetReq <= 1'b1;
        default: reset <= 1'b1;
      endcase
      @(posedge mclk);
      reset <= 1'b0;
      wait_sig(1'b1);
      chk(pipeFrozen === 1'b0 && busClockEn === 1'b1, "wake");
      @(posedge mclk);
      intPending <= 1'b0;
      nmiReq <= 1'b0;
      softResetReq <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
